// ==== src/tsens_bank.sv ====
// Pointer register and the four 16-bit sensor registers with byte sequencing.
module tsens_bank
    import tsens_pkg::*;
(
    input  wire logic  mclk,    // System clock.
    input  wire logic  arst_n,  // Asynchronous reset, active low.
    tsens_byte_if.bank bus,     // Byte accesses from the front end.
    input  wire logic [15:0] tempIn,     // Newest conversion result.
    input  wire logic        tempValid,  // One-cycle pulse, tempIn is new.
    output logic [7:0]  pointer,   // Pointer register value.
    output logic [15:0] configReg  // Configuration register value.
);
    import tsens_pkg::*;

    typedef struct packed {
        logic [1:0]  sel;
        logic [15:0] temp;
        logic [15:0] cfg;
        logic [15:0] lowTh;
        logic [15:0] highTh;
        logic [7:0]  msbHold;
        logic        lsbPhase;
        logic [7:0]  rdByte;
    } bank_type;

    bank_type s_q;
    bank_type s_d;
    logic [15:0] selWord;

    // Word currently chosen by the pointer.
    always_comb begin
        unique case (reg_sel_type'(s_q.sel))
            SEL_TEMPERATURE: selWord = s_q.temp;
            SEL_CONFIG:      selWord = s_q.cfg;
            SEL_LOW_ALARM:   selWord = s_q.lowTh;
            SEL_HIGH_ALARM:  selWord = s_q.highTh;
        endcase
    end

    // Next-state logic for pointer, data registers and byte phase.
    always_comb begin
        s_d = s_q;
        if (bus.wrStb) begin
            if (bus.first) begin
                s_d.sel      = bus.writeByte[1:0];
                s_d.lsbPhase = 1'b0;
            end else if (!s_q.lsbPhase) begin
                s_d.msbHold  = bus.writeByte;
                s_d.lsbPhase = 1'b1;
            end else begin
                s_d.lsbPhase = 1'b0;
                unique case (reg_sel_type'(s_q.sel))
                    SEL_TEMPERATURE: s_d.temp = s_q.temp;
                    SEL_CONFIG: s_d.cfg = ({s_q.msbHold, bus.writeByte} & CONFIG_WMASK)
                                        | (s_q.cfg & ~CONFIG_WMASK);
                    SEL_LOW_ALARM:  s_d.lowTh  = {s_q.msbHold, bus.writeByte};
                    SEL_HIGH_ALARM: s_d.highTh = {s_q.msbHold, bus.writeByte};
                endcase
            end
        end
        // A new conversion result lands last, so a discarded host write cannot undo it.
        if (tempValid) begin
            s_d.temp = tempIn;
        end
        // Read bytes: most significant first, then least significant.
        if (bus.rdStb) begin
            s_d.lsbPhase = bus.first ? 1'b1 : ~s_q.lsbPhase;
        end
        s_d.rdByte = (bus.rdStb ? s_d.lsbPhase : s_q.lsbPhase) ? selWord[7:0]
                                                                : selWord[15:8];
    end

    // State register.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{sel: PTR_RESET[1:0], temp: TEMP_RESET, cfg: CONFIG_RESET,
                     lowTh: LOW_ALARM_RESET, highTh: HIGH_ALARM_RESET,
                     msbHold: 8'h00, lsbPhase: 1'b0, rdByte: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.readByte = s_q.rdByte;
    assign pointer      = {6'h00, s_q.sel};
    assign configReg    = s_q.cfg;
endmodule

// ==== src/tsens_byte_if.sv ====
// Interface carrying byte-level accesses from the serial front end to the register bank.
interface tsens_byte_if;
    logic       wrStb;   // One-cycle pulse, writeByte is valid.
    logic       rdStb;   // One-cycle pulse, a read byte is consumed.
    logic       first;   // High for the first data byte after the address byte.
    logic [7:0] writeByte;
    logic [7:0] readByte;

    modport bank (input wrStb, rdStb, first, writeByte, output readByte);
    modport front (output wrStb, rdStb, first, writeByte, input readByte);
endinterface

// ==== src/tsens_pkg.sv ====
// Package with register map, field layout and reset values of the sensor register bank.
package tsens_pkg;

    localparam int unsigned REG_WIDTH = 16;
    localparam int unsigned PTR_WIDTH = 8;
    localparam int unsigned SEL_WIDTH = 2;

    // Register-select codes carried in the pointer.
    typedef enum logic [1:0] {
        SEL_TEMPERATURE = 2'h0,
        SEL_CONFIG      = 2'h1,
        SEL_LOW_ALARM   = 2'h2,
        SEL_HIGH_ALARM  = 2'h3
    } reg_sel_type;

    localparam logic [7:0]  PTR_RESET       = 8'h00;
    localparam logic [15:0] CONFIG_RESET    = 16'h40a0;
    localparam logic [15:0] LOW_ALARM_RESET = 16'h4b00;
    localparam logic [15:0] HIGH_ALARM_RESET = 16'h5000;
    localparam logic [15:0] TEMP_RESET      = 16'h0000;

    // Bits of the configuration word the host may change.
    localparam logic [15:0] CONFIG_WMASK    = 16'h9fd0;

endpackage

// ==== src/tsens_regs.sv ====
// Two-wire serial target front end wrapping the sensor register bank.
// Functional notes
// - Pointer is 8 bits; bits 0 and 1 are read/write and reset to zero.
// - Pointer bits 2 to 7 read zero; writes to them are ignored.
// - The 2-bit pointer chooses the register a following data access uses.
// - Pointer 0 selects the latest temperature result.
// - Pointers 1, 2, 3 select configuration, low and high thresholds.
// - Host writes never change the temperature result.
// - Configuration (CONFIG_WMASK bits only) and both thresholds are writable and read back.
// - Registers are reached only over the two-wire bus, device as target.
// - Each 16-bit transfer carries the high byte first, then low byte.
module tsens_regs
    import tsens_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h48  // Target address, arbitrary default.
) (
    input  wire logic        mclk,        // System clock, 40 MHz.
    input  wire logic        arst_n,      // Asynchronous reset, active low.
    input  wire logic        sclIn,       // Serial clock pin.
    input  wire logic        sdaIn,       // Serial data pin level.
    output logic             sdaOut,      // Serial data drive value, always low.
    output logic             sdaOe,       // Serial data enable, high pulls low.
    input  wire logic [15:0] tempIn,      // Conversion result.
    input  wire logic        tempValid,   // One-cycle pulse, new result.
    output logic [7:0]       pointer,     // Pointer register.
    output logic [15:0]      configReg    // Configuration register.
);
    import tsens_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b011,
        ST_WDAT = 3'b010,
        ST_RDAT = 3'b110,
        ST_DACK = 3'b111,
        ST_MACK = 3'b101
    } fsm_type;

    typedef struct packed {
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic       sclPrev;
        logic       sdaPrev;
        fsm_type    state;
        logic [7:0] shift;
        logic [2:0] bitCnt;
        logic       readMode;
        logic       firstByte;
        logic       drive;
        logic       wrStb;
        logic       rdStb;
        logic       first;
        logic [7:0] wByte;
        logic       byteDone;  // Eight bits shifted in, byte waits for the falling edge.
    } front_type;

    front_type f_q;
    front_type f_d;
    logic scl;
    logic sda;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    tsens_byte_if byteBus ();

    tsens_bank bank (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .bus       (byteBus.bank),
        .tempIn    (tempIn),
        .tempValid (tempValid),
        .pointer   (pointer),
        .configReg (configReg)
    );

    // Edge and bus-condition detection on synchronised pins.
    assign scl       = f_q.sclSync[1];
    assign sda       = f_q.sdaSync[1];
    assign sclRise   = scl & ~f_q.sclPrev;
    assign sclFall   = ~scl & f_q.sclPrev;
    assign startCond = scl & f_q.sclPrev & f_q.sdaPrev & ~sda;
    assign stopCond  = scl & f_q.sclPrev & ~f_q.sdaPrev & sda;

    // Serial target state machine; the only path into the registers.
    always_comb begin
        f_d = f_q;
        f_d.sclSync = {f_q.sclSync[0], sclIn};
        f_d.sdaSync = {f_q.sdaSync[0], sdaIn};
        f_d.sclPrev = scl;
        f_d.sdaPrev = sda;
        f_d.wrStb   = 1'b0;
        f_d.rdStb   = 1'b0;
        // A start condition restarts the address phase from any state.
        if (startCond) begin
            f_d.state    = ST_ADDR;
            f_d.bitCnt   = 3'h0;
            f_d.byteDone = 1'b0;
            f_d.drive    = 1'b0;
        end else if (stopCond) begin
            f_d.state    = ST_IDLE;
            f_d.byteDone = 1'b0;
            f_d.drive    = 1'b0;
        end else begin
            unique case (f_q.state)
                // Bus free: nothing is driven.
                ST_IDLE: f_d.drive = 1'b0;
                // Eight rising edges shift a byte in; it is used on the next falling edge.
                ST_ADDR, ST_WDAT: begin
                    if (sclRise) begin
                        f_d.shift  = {f_q.shift[6:0], sda};
                        f_d.bitCnt = f_q.bitCnt + 3'h1;
                        if (f_q.bitCnt == 3'h7) begin
                            f_d.byteDone = 1'b1;
                        end
                    end
                    // The falling edge that ends the start condition carries no byte.
                    if (sclFall && f_q.byteDone) begin
                        f_d.byteDone = 1'b0;
                        if (f_q.state == ST_ADDR) begin
                            if (f_q.shift[7:1] == DEV_ADDR) begin
                                f_d.readMode  = f_q.shift[0];
                                f_d.firstByte = 1'b1;
                                f_d.drive     = 1'b1;
                                f_d.state     = ST_AACK;
                            end else begin
                                f_d.state = ST_IDLE;
                            end
                        end else begin
                            f_d.wrStb     = 1'b1;
                            f_d.first     = f_q.firstByte;
                            f_d.wByte     = f_q.shift;
                            f_d.firstByte = 1'b0;
                            f_d.drive     = 1'b1;
                            f_d.state     = ST_AACK;
                        end
                    end
                end
                // Acknowledge slot: on the falling edge that ends it, a write releases the line and a read drives the first data bit.
                ST_AACK: begin
                    if (sclFall) begin
                        if (f_q.readMode) begin
                            f_d.shift = byteBus.readByte;
                            f_d.drive = ~byteBus.readByte[7];
                            f_d.state = ST_RDAT;
                        end else begin
                            f_d.drive = 1'b0;
                            f_d.state = ST_WDAT;
                        end
                        f_d.bitCnt = 3'h0;
                    end
                end
                // Read data: the next bit is put out after each falling edge.
                ST_RDAT: begin
                    if (sclFall) begin
                        f_d.bitCnt = f_q.bitCnt + 3'h1;
                        f_d.shift  = {f_q.shift[6:0], 1'b0};
                        if (f_q.bitCnt == 3'h7) begin
                            f_d.drive = 1'b0;
                            f_d.rdStb = 1'b1;
                            f_d.first = f_q.firstByte;
                            f_d.firstByte = 1'b0;
                            f_d.state = ST_MACK;
                        end else begin
                            f_d.drive = ~f_q.shift[6];
                        end
                    end
                end
                // Host acknowledge: a high level ends the read.
                ST_MACK: begin
                    if (sclRise) begin
                        f_d.state = sda ? ST_IDLE : ST_DACK;
                    end
                end
                // Host asked for more: load the next byte of the word.
                ST_DACK: begin
                    if (sclFall) begin
                        f_d.shift  = byteBus.readByte;
                        f_d.drive  = ~byteBus.readByte[7];
                        f_d.bitCnt = 3'h0;
                        f_d.state  = ST_RDAT;
                    end
                end
                // Unused code: fall back to the idle state.
                default: f_d.state = ST_IDLE;
            endcase
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // Pin history resets to the idle-high bus so no false edge follows reset.
            f_q <= '{
                sclSync:   2'b11,
                sdaSync:   2'b11,
                sclPrev:   1'b1,
                sdaPrev:   1'b1,
                state:     ST_IDLE,
                shift:     8'h00,
                bitCnt:    3'h0,
                readMode:  1'b0,
                firstByte: 1'b0,
                drive:     1'b0,
                wrStb:     1'b0,
                rdStb:     1'b0,
                first:     1'b0,
                wByte:     8'h00,
                byteDone:  1'b0
            };
        end else begin
            f_q <= f_d;
        end
    end

    // Byte strobes toward the bank and open-drain drive.
    assign byteBus.wrStb     = f_q.wrStb;
    assign byteBus.rdStb     = f_q.rdStb;
    assign byteBus.first     = f_q.first;
    assign byteBus.writeByte = f_q.wByte;
    assign sdaOut            = 1'b0;
    assign sdaOe             = f_q.drive;
endmodule

// ==== test/test_temp_sensor_register_pointer.sv ====
// Self-checking bench for the sensor register pointer and register bank.
module test_temp_sensor_register_pointer import tsens_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0]  ADDR = 7'h35;           // Target address, arbitrary.
    localparam logic [7:0]  WR = {ADDR, 1'b0};      // Address byte for writes.
    localparam logic [7:0]  RD = {ADDR, 1'b1};      // Address byte for reads.
    localparam logic [15:0] WVAL [1:3] = '{16'hffff, 16'h1234, 16'h8a5c};
    localparam logic [15:0] CFG_EXP = (16'hffff & CONFIG_WMASK) | (CONFIG_RESET & ~CONFIG_WMASK);
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] tempIn = 16'h0000;
    logic        tempValid = 1'b0;
    logic        sdaOut;
    logic        sdaOe;
    logic [7:0]  pointer;
    logic [15:0] configReg;
    logic        scl;
    logic        sdaRel;
    logic        sdaLine;
    logic        ok;
    logic [15:0] val;
    int          errorCnt = 0;
    int          nCompared = 0;
    int          cycles = 0;

    always #12.5 mclk = ~mclk;
    // Pulled-up data line: low when either party pulls it low.
    assign sdaLine = sdaRel & (sdaOe ? sdaOut : 1'b1);

    tsens_regs #(.DEV_ADDR(ADDR)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .tempIn(tempIn), .tempValid(tempValid), .pointer(pointer),
        .configReg(configReg));
    tsens_host u_host (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaRel(sdaRel));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic testDone();
        $display("mismatches %0d, comparisons %0d", errorCnt, nCompared);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            errorCnt++;
            testDone();
        end
    end

    // Main sequence of bus accesses with expected values.
    initial begin
        repeat (10) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check({8'h00, pointer}, 16'h0000);
        check(configReg, CONFIG_RESET);
        u_host.readReg(RD, val, ok);
        check(val, TEMP_RESET);
        check({15'h0000, ok}, 16'h0001);
        tempIn = 16'h1a2b;
        tempValid = 1'b1;
        @(negedge mclk);
        tempValid = 1'b0;
        u_host.readReg(RD, val, ok);
        check(val, 16'h1a2b);
        u_host.readReg(RD, val, ok);
        check(val, 16'h1a2b);
        u_host.writeReg(WR, 8'h00, 1'b1, 16'hffff, ok);
        u_host.readReg(RD, val, ok);
        check(val, 16'h1a2b);
        for (int p = 1; p < 4; p++) begin
            u_host.writeReg(WR, 8'hfc | 8'(p), 1'b1, WVAL[p], ok);
            check({8'h00, pointer}, 16'(p));
        end
        check(configReg, CFG_EXP);
        for (int p = 1; p < 4; p++) begin
            u_host.writeReg(WR, 8'(p), 1'b0, 16'h0000, ok);
            u_host.readReg(RD, val, ok);
            check(val, (p == 1) ? CFG_EXP : WVAL[p]);
        end
        u_host.readReg(RD ^ 8'h02, val, ok);
        check({15'h0000, ok}, 16'h0000);
        check(val, 16'hffff);
        u_host.writeReg(WR ^ 8'h02, 8'h01, 1'b0, 16'h0000, ok);
        check({8'h00, pointer}, 16'h0003);
        u_host.half = 25;
        u_host.readReg(RD, val, ok);
        check(val, WVAL[3]);
        testDone();
    end
endmodule

// ==== test/tsens_host.sv ====
// Behavioural two-wire bus host that drives the sensor's serial pins.
module tsens_host (
    input  wire logic mclk,    // System clock, paces the bit timing.
    input  wire logic sdaLine, // Resolved data line level.
    output logic      scl,     // Serial clock driven by the host.
    output logic      sdaRel   // High releases the data line.
);
    timeunit 1ns;
    timeprecision 100ps;
    int half = 10; // Half period of the serial clock in system cycles.

    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic pause();
        repeat (half) @(negedge mclk);
    endtask
    // Start condition: data falls while the clock is high.
    task automatic startBit();
        pause();
        sdaRel = 1'b0;
        pause();
        scl = 1'b0;
    endtask
    // Stop condition: data rises while the clock is high.
    task automatic stopBit();
        repeat (2) @(negedge mclk);
        sdaRel = 1'b0;
        pause();
        scl = 1'b1;
        pause();
        sdaRel = 1'b1;
    endtask
    // Data moves while the clock is low and is sampled at the end of the high phase.
    task automatic bitXfer(input logic b, output logic r);
        repeat (2) @(negedge mclk);
        sdaRel = b;
        pause();
        scl = 1'b1;
        pause();
        r = sdaLine;
        scl = 1'b0;
    endtask
    // One byte, most significant bit first, then the acknowledge slot.
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitXfer(d[i], r);
            q[i] = r;
        end
        bitXfer(last, r);
        ack = ~r;
    endtask
    // Pointer load, then the word high byte first when withData is set.
    task automatic writeReg(input logic [7:0] a, input logic [7:0] ptr, input logic withData,
                            input logic [15:0] v, output logic ok);
        logic [7:0] q;
        logic       k;
        startBit();
        xfer(a, 1'b1, q, ok);
        xfer(ptr, 1'b1, q, k);
        if (withData) begin
            xfer(v[15:8], 1'b1, q, k);
            xfer(v[7:0], 1'b1, q, k);
        end
        stopBit();
    endtask
    // Word read: the high byte is acknowledged, the low byte refused.
    task automatic readReg(input logic [7:0] a, output logic [15:0] v, output logic ok);
        logic k;
        startBit();
        xfer(a, 1'b1, v[7:0], ok);
        xfer(8'hff, 1'b0, v[15:8], k);
        xfer(8'hff, 1'b1, v[7:0], k);
        stopBit();
    endtask
endmodule

// ==== test/tsens_regs_monitor.sv ====
// Checker of the serial pins and register outputs of the sensor register front end.
module tsens_regs_monitor
    import tsens_pkg::*;
(
    input wire logic        mclk,      // System clock.
    input wire logic        arst_n,    // Asynchronous reset, active low.
    input wire logic        sclIn,     // Serial clock pin.
    input wire logic        sdaIn,     // Serial data pin.
    input wire logic        sdaOut,    // Data drive value.
    input wire logic        sdaOe,     // Data drive enable.
    input wire logic [15:0] tempIn,    // Conversion result.
    input wire logic        tempValid, // New result strobe.
    input wire logic [7:0]  pointer,   // Pointer register.
    input wire logic [15:0] configReg  // Configuration register.
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] RO_BITS = ~CONFIG_WMASK;  // Configuration bits the host cannot change.
    default clocking monClk @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Register state right after reset and between bus events.
    chk_ptr_upper: assert property (pointer[7:2] == 6'h00)
        else $error("pointer upper bits not zero");
    chk_ptr_reset: assert property (!$past(arst_n) |-> pointer == PTR_RESET)
        else $error("pointer not cleared by reset");
    chk_cfg_reset: assert property (!$past(arst_n) |-> configReg == CONFIG_RESET)
        else $error("configuration reset value wrong");
    chk_ptr_quiet: assert property ($stable(sclIn) [*8] |-> $stable(pointer))
        else $error("pointer changed with the serial clock idle");
    chk_cfg_quiet: assert property ($stable(sclIn) [*8] |-> $stable(configReg))
        else $error("configuration changed with the serial clock idle");
    chk_cfg_fixed: assert property ((configReg & RO_BITS) == (CONFIG_RESET & RO_BITS))
        else $error("read-only configuration bits changed");

    // Open-drain data drive only changes while the serial clock is low and stands at least eight cycles.
    chk_drive_low: assert property (sdaOe |-> sdaOut == 1'b0)
        else $error("data line driven high");
    chk_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data drive changed while clock high");
    chk_oe_stands: assert property ($rose(sdaOe) |-> sdaOe [*8])
        else $error("data drive too short");

    cov_ack: cover property ($rose(sdaOe));
    cov_ptr_top: cover property (pointer == 8'h03);
    cov_cfg_write: cover property ($changed(configReg));
endmodule

bind tsens_regs tsens_regs_monitor u_monitor (
    .mclk(mclk), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .tempIn(tempIn), .tempValid(tempValid), .pointer(pointer),
    .configReg(configReg)
);
